/* File: static_branch_predictor_ras.sv */
// Purpose: front-end static prediction, return stack, spin hint
// Assumes: one fetched branch per cycle, resolution from execute
// Notes:   prediction registered one cycle after the fetch strobe
`timescale 1ns/1ps
`include "bpred_consts.svh"
// Notes on behaviour
// - no history entry means static rules used
// - unconditional branches predicted taken
// - indirect branches predicted not taken
// - backward conditional taken in direction mode
// - forward conditional not taken in direction mode
// - dynamic mode ignores jump direction
// - no-static mode omits the heuristic
// - sixteen-entry return stack, calls push, returns pop
// - resident trace prediction overrides stack
// - spin hint retires as no-op
// - spin hint softens order-violation flush
// - indirect with history uses last target
module static_branch_predictor_ras
	import bpred_pkg::*;
#(
	parameter int AW = `ADDR_W
) (
	input  wire logic          clk,
	input  wire logic          arst_n,
	input  bpred_pkg::predMode_t mode,
	input  wire logic          fetchValid,
	input  bpred_pkg::brKind_t fetchKind,
	input  wire logic [AW-1:0] fetchPc,
	input  wire logic [AW-1:0] fetchTarget,
	input  wire logic          histHit,
	input  wire logic          histTaken,
	input  wire logic [AW-1:0] histTarget,
	input  wire logic          traceHit,
	input  wire logic [AW-1:0] traceTarget,
	input  wire logic          loopExit,
	output logic               predValid,
	output logic               predTaken,
	output logic [AW-1:0]      predTarget,
	output logic               retireNop,
	output logic               spinActive,
	output logic               orderFlushMask
);
	logic          statTaken;
	logic [AW-1:0] rasTop;
	logic          push;
	logic          pop;
	logic          valid_q;
	logic          valid_d;
	logic          taken_q;
	logic          taken_d;
	logic [AW-1:0] tgt_q;
	logic [AW-1:0] tgt_d;
	logic          nop_q;
	logic          nop_d;
	logic          spin_q;
	logic          spin_d;
	logic          mask_q;
	logic          mask_d;

	static_dir u_dir (
		.kind   (fetchKind),
		.mode   (mode),
		.pc     (fetchPc),
		.target (fetchTarget),
		.taken  (statTaken)
	);

	assign push = fetchValid && (fetchKind == BR_CALL);
	assign pop  = fetchValid && (fetchKind == BR_RET);

	ret_stack #(
		.DEPTH (`RAS_DEPTH),
		.AW    (AW)
	) u_ras (
		.clk      (clk),
		.arst_n   (arst_n),
		.push     (push),
		.pushAddr (AW'(fetchPc + `CALL_LEN)),
		.pop      (pop),
		.topAddr  (rasTop)
	);

	always_comb
	begin
		valid_d = fetchValid;
		taken_d = 1'b0;
		tgt_d   = AW'(fetchPc + `CALL_LEN);
		nop_d   = 1'b0;
		spin_d  = spin_q;
		if (fetchValid)
		begin
			unique case (fetchKind)
				BR_CALL, BR_RET:
				begin
					taken_d = 1'b1;
					if (traceHit)
						tgt_d = traceTarget;
					else if (fetchKind == BR_RET)
						tgt_d = rasTop;
					else
						tgt_d = fetchTarget;
				end
				BR_SPIN:
				begin
					nop_d  = 1'b1;
					spin_d = 1'b1;
				end
				BR_NONE:
					taken_d = 1'b0;
				default:
				begin
					if (histHit && fetchKind == BR_INDIR)
					begin
						taken_d = 1'b1;
						tgt_d   = histTarget;
					end
					else if (histHit ||
						(fetchKind == BR_COND && mode == MODE_DYNAMIC))
					begin
						taken_d = histHit && histTaken;
						if (taken_d)
							tgt_d = fetchTarget;
					end
					else
					begin
						taken_d = statTaken;
						if (statTaken)
							tgt_d = fetchTarget;
					end
				end
			endcase
		end
		// loop exit ends the polling window after use
		if (loopExit && !(fetchValid && fetchKind == BR_SPIN))
			spin_d = 1'b0;
		mask_d = spin_d;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			valid_q <= 1'b0;
			taken_q <= 1'b0;
			tgt_q   <= '0;
			nop_q   <= 1'b0;
			spin_q  <= 1'b0;
			mask_q  <= 1'b0;
		end
		else
		begin
			valid_q <= valid_d;
			taken_q <= taken_d;
			tgt_q   <= tgt_d;
			nop_q   <= nop_d;
			spin_q  <= spin_d;
			mask_q  <= mask_d;
		end
	end

	assign predValid      = valid_q;
	assign predTaken      = taken_q;
	assign predTarget     = tgt_q;
	assign retireNop      = nop_q;
	assign spinActive     = spin_q;
	assign orderFlushMask = mask_q;

	a_uncond_taken: assert property (
		@(posedge clk) disable iff (!arst_n)
		fetchValid && fetchKind == BR_UNCOND && !histHit
		|=> predTaken && predTarget == $past(fetchTarget))
		else $error("unconditional branch not predicted taken");

	a_indir_nottaken: assert property (
		@(posedge clk) disable iff (!arst_n)
		fetchValid && fetchKind == BR_INDIR && !histHit
		|=> !predTaken)
		else $error("indirect branch without history predicted taken");

	a_back_taken: assert property (
		@(posedge clk) disable iff (!arst_n)
		fetchValid && fetchKind == BR_COND && !histHit
		&& mode == MODE_DIRECTION && fetchTarget < fetchPc
		|=> predTaken)
		else $error("backward conditional not predicted taken");

	a_fwd_fall: assert property (
		@(posedge clk) disable iff (!arst_n)
		fetchValid && fetchKind == BR_COND && !histHit
		&& mode == MODE_DIRECTION && fetchTarget > fetchPc
		|=> !predTaken)
		else $error("forward conditional predicted taken");

	a_dyn_nodir: assert property (
		@(posedge clk) disable iff (!arst_n)
		fetchValid && fetchKind == BR_COND && !histHit
		&& mode != MODE_DIRECTION |=> !predTaken)
		else $error("direction heuristic used outside direction mode");

	a_call_ret: assert property (
		@(posedge clk) disable iff (!arst_n)
		fetchValid && fetchKind == BR_CALL && !traceHit ##1
		fetchValid && fetchKind == BR_RET && !traceHit
		|=> predTaken && predTarget == $past(fetchPc, 2) + `CALL_LEN)
		else $error("return did not pop matching call address");

	a_trace_wins: assert property (
		@(posedge clk) disable iff (!arst_n)
		fetchValid && fetchKind == BR_RET && traceHit
		|=> predTarget == $past(traceTarget))
		else $error("trace prediction ignored for return");

	a_spin_nop: assert property (
		@(posedge clk) disable iff (!arst_n)
		fetchValid && fetchKind == BR_SPIN
		|=> retireNop && !predTaken && orderFlushMask)
		else $error("spin hint not retired as no-op");

	a_indir_hist: assert property (
		@(posedge clk) disable iff (!arst_n)
		fetchValid && fetchKind == BR_INDIR && histHit
		|=> predTaken && predTarget == $past(histTarget))
		else $error("indirect history target not used");

	a_valid_fall: assert property (
		@(posedge clk) disable iff (!arst_n)
		!fetchValid |=> !predValid && !predTaken && !retireNop)
		else $error("prediction shown without a fetch");

	a_indir_fall: assert property (
		@(posedge clk) disable iff (!arst_n)
		fetchValid && fetchKind == BR_INDIR && !histHit
		|=> predTarget == $past(fetchPc) + `CALL_LEN)
		else $error("indirect branch not sent down sequential path");

	a_back_target: assert property (
		@(posedge clk) disable iff (!arst_n)
		fetchValid && fetchKind == BR_COND && !histHit
		&& mode == MODE_DIRECTION && fetchTarget < fetchPc
		|=> predTarget == $past(fetchTarget))
		else $error("backward conditional target wrong");

	a_fwd_target: assert property (
		@(posedge clk) disable iff (!arst_n)
		fetchValid && fetchKind == BR_COND && !histHit
		&& mode == MODE_DIRECTION && fetchTarget > fetchPc
		|=> predTarget == $past(fetchPc) + `CALL_LEN)
		else $error("forward conditional not falling through");

	a_nostat_cond: assert property (
		@(posedge clk) disable iff (!arst_n)
		fetchValid && fetchKind == BR_COND && !histHit
		&& mode == MODE_NOSTATIC
		|=> !predTaken && predTarget == $past(fetchPc) + `CALL_LEN)
		else $error("conditional predicted by direction in no-static mode");

	a_call_taken: assert property (
		@(posedge clk) disable iff (!arst_n)
		fetchValid && fetchKind == BR_CALL && !traceHit
		|=> predTaken && predTarget == $past(fetchTarget))
		else $error("call not predicted to its target");

	a_call_trace: assert property (
		@(posedge clk) disable iff (!arst_n)
		fetchValid && fetchKind == BR_CALL && traceHit
		|=> predTaken && predTarget == $past(traceTarget))
		else $error("trace prediction ignored for call");

	a_nop_only: assert property (
		@(posedge clk) disable iff (!arst_n)
		!(fetchValid && fetchKind == BR_SPIN) |=> !retireNop)
		else $error("no-op retire without spin hint");

	a_spin_fall: assert property (
		@(posedge clk) disable iff (!arst_n)
		fetchValid && fetchKind == BR_SPIN
		|=> predTarget == $past(fetchPc) + `CALL_LEN)
		else $error("spin hint redirected fetch");

	a_spin_hold: assert property (
		@(posedge clk) disable iff (!arst_n)
		spinActive && !loopExit
		|=> spinActive && orderFlushMask)
		else $error("polling window dropped without loop exit");

	a_spin_clear: assert property (
		@(posedge clk) disable iff (!arst_n)
		loopExit && !(fetchValid && fetchKind == BR_SPIN)
		|=> !spinActive && !orderFlushMask)
		else $error("polling window not closed on loop exit");
endmodule

/* File: bpred_consts.svh */
// Purpose: constants for the static branch predictor and return stack
// Assumes: 100 MHz core clock
// Notes:   modes select the static direction heuristic
`ifndef BPRED_CONSTS_SVH
`define BPRED_CONSTS_SVH
`define ADDR_W        32
`define RAS_DEPTH     16
`define RAS_PTR_W     4
`define CALL_LEN      32'h0000_0004
`define MODE_W        2
`define MODE_DIR      2'h0
`define MODE_DYN      2'h1
`define MODE_NONE     2'h2
`endif

/* File: bpred_pkg.sv */
// Purpose: types for the static branch predictor
// Assumes: constants header present
// Notes:   branch kinds as decoded by fetch
`include "bpred_consts.svh"
package bpred_pkg;
	typedef enum logic [2:0]
	{
		BR_NONE   = 3'h0,
		BR_UNCOND = 3'h1,
		BR_COND   = 3'h2,
		BR_INDIR  = 3'h3,
		BR_CALL   = 3'h4,
		BR_RET    = 3'h5,
		BR_SPIN   = 3'h6
	} brKind_t;
	typedef enum logic [1:0]
	{
		MODE_DIRECTION = 2'h0,
		MODE_DYNAMIC   = 2'h1,
		MODE_NOSTATIC  = 2'h2
	} predMode_t;
endpackage

/* File: ret_stack.sv */
// Purpose: circular return address stack
// Assumes: one push or pop per cycle, push wins if both
// Notes:   overflow wraps onto the oldest entry
`timescale 1ns/1ps
`include "bpred_consts.svh"
module ret_stack #(
	parameter int DEPTH = `RAS_DEPTH,
	parameter int AW    = `ADDR_W
) (
	input  wire logic          clk,
	input  wire logic          arst_n,
	input  wire logic          push,
	input  wire logic [AW-1:0] pushAddr,
	input  wire logic          pop,
	output logic      [AW-1:0] topAddr
);
	localparam int PW = $clog2(DEPTH);
	logic [AW-1:0] mem_q [DEPTH];
	logic [AW-1:0] mem_d [DEPTH];
	logic [PW-1:0] ptr_q;
	logic [PW-1:0] ptr_d;

	assign topAddr = mem_q[ptr_q - PW'(1)];

	always_comb
	begin
		mem_d = mem_q;
		ptr_d = ptr_q;
		if (push)
		begin
			mem_d[ptr_q] = pushAddr;
			ptr_d = ptr_q + PW'(1);
		end
		else if (pop)
			ptr_d = ptr_q - PW'(1);
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ptr_q <= '0;
			for (int i = 0; i < DEPTH; i++)
				mem_q[i] <= '0;
		end
		else
		begin
			ptr_q <= ptr_d;
			mem_q <= mem_d;
		end
	end

	a_ptr_wrap: assert property (
		@(posedge clk) disable iff (!arst_n)
		push |=> ptr_q == $past(ptr_q) + PW'(1))
		else $error("stack pointer did not advance on push");
endmodule

/* File: static_dir.sv */
// Purpose: static direction for branches with no history
// Assumes: pure combinational decision
// Notes:   calls and returns handled by the stack elsewhere
`timescale 1ns/1ps
`include "bpred_consts.svh"
module static_dir
	import bpred_pkg::*;
(
	input  bpred_pkg::brKind_t   kind,
	input  bpred_pkg::predMode_t mode,
	input  wire logic [31:0]     pc,
	input  wire logic [31:0]     target,
	output logic                 taken
);
	always_comb
	begin
		taken = 1'b0;
		unique case (kind)
			BR_UNCOND: taken = 1'b1;
			BR_INDIR: taken = 1'b0;
			BR_COND: taken = (mode == MODE_DIRECTION) && (target < pc);
			default: taken = 1'b0;
		endcase
	end
endmodule

/* File: hist_model.sv */
// Purpose: one-entry target history model for the predictor bench
// Assumes: resolution writes one branch per clock
// Notes:   a single entry keeps hit and miss cases easy to steer
`timescale 1ns/1ps
module hist_model
(
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        wrEn,
	input  wire logic [31:0] wrPc,
	input  wire logic [31:0] wrTarget,
	input  wire logic [31:0] pc,
	output logic             hit,
	output logic             taken,
	output logic [31:0]      target
);
	logic        valid_q;
	logic [31:0] pc_q;
	logic [31:0] tgt_q;
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			valid_q <= 1'b0;
			pc_q    <= 32'h0;
			tgt_q   <= 32'h0;
		end
		else if (wrEn)
		begin
			valid_q <= 1'b1;
			pc_q    <= wrPc;
			tgt_q   <= wrTarget;
		end
	end
	assign hit    = valid_q && (pc_q == pc);
	assign taken  = hit;
	// a miss shows an inverted target, never a stale match
	assign target = hit ? tgt_q : ~tgt_q;
endmodule

/* File: static_branch_predictor_ras_tb.sv */
// Purpose: self-checking bench for the static predictor
// Assumes: outputs settle one clock after each fetch
// Notes:   inputs move on the falling edge only
`timescale 1ns/1ps
module static_branch_predictor_ras_tb;
	import bpred_pkg::*;
	logic        clk = 0, arst_n = 0, fetchValid = 0;
	logic        traceHit = 0, loopExit = 0, wrEn = 0;
	predMode_t   mode = MODE_DIRECTION;
	brKind_t     fetchKind = BR_NONE;
	logic [31:0] fetchPc = '0, fetchTarget = '0, traceTarget = '0;
	logic [31:0] wrPc = '0, wrTarget = '0, histTarget, predTarget;
	logic        histHit, histTaken, predValid, predTaken;
	logic        retireNop, spinActive, orderFlushMask;
	int          failures = 0, tests_run = 0;
	always #5 clk = ~clk;
	hist_model hm (.clk(clk), .arst_n(arst_n), .wrEn(wrEn), .wrPc(wrPc),
		.wrTarget(wrTarget), .pc(fetchPc), .hit(histHit),
		.taken(histTaken), .target(histTarget));
	static_branch_predictor_ras dut (.clk(clk), .arst_n(arst_n),
		.mode(mode), .fetchValid(fetchValid), .fetchKind(fetchKind),
		.fetchPc(fetchPc), .fetchTarget(fetchTarget), .histHit(histHit),
		.histTaken(histTaken), .histTarget(histTarget),
		.traceHit(traceHit), .traceTarget(traceTarget),
		.loopExit(loopExit), .predValid(predValid),
		.predTaken(predTaken), .predTarget(predTarget),
		.retireNop(retireNop), .spinActive(spinActive),
		.orderFlushMask(orderFlushMask));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic fetch(input brKind_t k, input logic [31:0] pc, tg);
		fetchValid  = 1'b1;
		fetchKind   = k;
		fetchPc     = pc;
		fetchTarget = tg;
		@(negedge clk);
	endtask
	task automatic idle();
		fetchValid = 1'b0;
		traceHit   = 1'b0;
		@(negedge clk);
	endtask
	task automatic step(input brKind_t k, input logic [31:0] pc, tg,
		input logic t, input logic [31:0] et);
		fetch(k, pc, tg);
		check({predValid, predTaken}, {1'b1, t});
		check(predTarget, et);
	endtask
	task automatic t_static();
		step(BR_UNCOND, 32'h100, 32'h200, 1, 32'h200);
		step(BR_INDIR, 32'h300, 32'h900, 0, 32'h304);
		step(BR_COND, 32'h400, 32'h380, 1, 32'h380);
		step(BR_COND, 32'h400, 32'h480, 0, 32'h404);
		mode = MODE_DYNAMIC;
		step(BR_COND, 32'h400, 32'h380, 0, 32'h404);
		mode = MODE_NOSTATIC;
		step(BR_COND, 32'h400, 32'h380, 0, 32'h404);
		mode = MODE_DIRECTION;
		idle();
		check(predValid, 1'b0);
	endtask
	task automatic t_hist();
		wrEn     = 1'b1;
		wrPc     = 32'h500;
		wrTarget = 32'h9A0;
		@(negedge clk);
		wrEn = 1'b0;
		step(BR_INDIR, 32'h500, 32'h0, 1, 32'h9A0);
		idle();
	endtask
	// seventeen calls overflow the sixteen-entry stack, then sixteen returns unwind it
	task automatic t_stack();
		for (int i = 0; i < 17; i++)
			step(BR_CALL, 32'h1000 + i * 16, 32'h8000, 1, 32'h8000);
		for (int j = 16; j > 0; j--)
			step(BR_RET, 32'h0, 32'h0, 1, 32'h1004 + j * 16);
		idle();
	endtask
	task automatic t_trace();
		step(BR_CALL, 32'h2000, 32'h6000, 1, 32'h6000);
		traceHit    = 1'b1;
		traceTarget = 32'h7770;
		step(BR_RET, 32'h0, 32'h0, 1, 32'h7770);
		idle();
	endtask
	task automatic t_spin();
		fetch(BR_SPIN, 32'h3000, 32'h0);
		check({retireNop, spinActive, orderFlushMask}, 3'h7);
		check(predTaken, 1'b0);
		idle();
		check({retireNop, spinActive, orderFlushMask}, 3'h3);
		loopExit = 1'b1;
		@(negedge clk);
		loopExit = 1'b0;
		check({spinActive, orderFlushMask}, 2'h0);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(negedge clk);
		check({predValid, predTaken, retireNop, spinActive}, 4'h0);
		arst_n = 1'b1;
		@(negedge clk);
		t_static();
		t_hist();
		t_stack();
		t_trace();
		t_spin();
		complete_run();
	end
endmodule
